// [design/sticky_flag.sv]
/*
  One sticky event flag: set by a hardware pulse, cleared by software.
  Assumes set and clear are both synchronous to pclk.
*/
`timescale 1ns/100ps

module sticky_flag (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Event and clear
  input wire logic set,
  input wire logic clr,
  // Flag
  output logic flag
);
  // Set wins so an event in the clearing cycle is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

  a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (set && clr) |=> flag)
    else $error("event lost against simultaneous clear");
endmodule // sticky_flag

// [design/tx_cmd_decode.sv]
/*
  Transmit command word decoder: package of constants and types, then the
  decoder that parses each buffer's command words, strips offset bytes and
  end-alignment padding, and reports completion and faults over APB.
  Assumes a single pclk domain; the write stream and the payload sink are
  logic on the same clock, and software reaches the flags over APB.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - With the completion-request bit set, the loaded flag rises once the whole buffer is taken.
// - The loaded flag can be routed onto the interrupt output under software control.
// - Padding words are swallowed and never reach the payload output.
// - Alignment code 00 means 4 bytes, 01 means 16, 10 means 32, and 11 is reserved.
// - The five-bit offset names the byte where payload starts, and output begins there.
// - The offset may reach into the first eight words, and all bytes before it are dropped.
// - First and last segment bits delimit packets on the payload output.
// - Buffer sizes of a packet are summed, and a mismatch with the packet length raises a fault.
package tx_cmd_pkg;
  // ------------------------------------------------------------
  // Register map and flag positions
  // ------------------------------------------------------------
  localparam logic [11:0] status_addr = 12'h000;
  localparam logic [11:0] mask_addr = 12'h004;
  localparam logic [11:0] info_addr = 12'h008;
  localparam int loaded_bit = 0;
  localparam int fault_bit = 1;
  localparam int num_flags = 2;
  localparam logic [1:0] mask_reset = 2'h0;
  // ------------------------------------------------------------
  // Alignment codes and their dword masks
  // ------------------------------------------------------------
  localparam logic [1:0] align_4 = 2'h0;
  localparam logic [1:0] align_16 = 2'h1;
  localparam logic [1:0] align_32 = 2'h2;
  localparam logic [1:0] align_rsvd = 2'h3;
  localparam logic [11:0] dw_mask_4 = 12'h000;
  localparam logic [11:0] dw_mask_16 = 12'h003;
  localparam logic [11:0] dw_mask_32 = 12'h007;

  typedef struct packed {
    logic done_req;
    logic [4:0] rsvd_hi;
    logic [1:0] end_align;
    logic [2:0] rsvd_mid;
    logic [4:0] start_off;
    logic [1:0] rsvd_lo;
    logic first_piece_marker;
    logic last_piece_marker;
    logic rsvd_size;
    logic [10:0] buf_size;
  } cmd_a_s;

  typedef struct packed {
    logic [15:0] tag;
    logic [4:0] rsvd;
    logic [10:0] pkt_len;
  } cmd_b_s;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] be;
    logic first;
    logic last;
  } payload_s;

  typedef enum logic [1:0] {
    st_cmd_a = 2'h0,
    st_cmd_b = 2'h1,
    st_data = 2'h3
  } state_e;
endpackage

module tx_cmd_decode import tx_cmd_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command and payload words from the host
  input wire logic wr_valid,
  input wire logic [31:0] wr_data,
  output logic wr_ready,
  // Payload toward the transmit FIFO
  output payload_s out_word,
  output logic out_valid,
  input wire logic out_ready,
  // Interrupt
  output logic irq
);
  // ------------------------------------------------------------
  // Command decode and buffer geometry
  // ------------------------------------------------------------
  state_e state;
  state_e next_state;
  cmd_a_s cmd_a;
  logic [10:0] size_sum;
  logic [11:0] idx;
  logic [num_flags-1:0] mask;
  logic [num_flags-1:0] flags;
  logic [31:0] next_rdata;

  cmd_a_s wr_as_a;
  cmd_b_s wr_as_b;
  assign wr_as_a = cmd_a_s'(wr_data);
  assign wr_as_b = cmd_b_s'(wr_data);

  wire accept = wr_valid && wr_ready;
  // Reserved fields are never looked at, so stray bits cannot upset decode
  wire [11:0] end_byte = {7'h00, cmd_a.start_off} + {1'b0, cmd_a.buf_size};
  wire [11:0] data_dw = 12'(({1'b0, end_byte} + 13'h003) >> 2);
  wire [11:0] skip_dw = {9'h000, cmd_a.start_off[4:2]};
  wire [11:0] dw_mask = (cmd_a.end_align == align_16) ? dw_mask_16 :
                        (cmd_a.end_align == align_32) ? dw_mask_32 : dw_mask_4;
  // Words of the buffer including padding, rounded up to the boundary
  wire [11:0] total_dw = (data_dw + dw_mask) & ~dw_mask;
  wire last_dw = (idx == total_dw - 12'h001);
  wire keep = (idx >= skip_dw) && (idx < data_dw);
  wire emit = (state == st_data) && accept && keep;
  wire [3:0] lo_be = (idx == skip_dw) ? (4'hF << cmd_a.start_off[1:0]) : 4'hF;
  wire [3:0] hi_be = ((idx != data_dw - 12'h001) || (end_byte[1:0] == 2'h0)) ? 4'hF :
                     (4'hF >> (3'h4 - {1'b0, end_byte[1:0]}));
  wire [10:0] new_sum = (cmd_a.first_piece_marker ? 11'h000 : size_sum) + cmd_a.buf_size;
  wire b_taken = (state == st_cmd_b) && accept;
  wire len_bad = b_taken && cmd_a.last_piece_marker && (new_sum != wr_as_b.pkt_len);
  wire align_bad = b_taken && (cmd_a.end_align == align_rsvd);
  wire empty_buf = (total_dw == 12'h000);
  wire loaded_evt = cmd_a.done_req &&
                    ((b_taken && empty_buf) || ((state == st_data) && accept && last_dw));
  wire fault_evt = len_bad || align_bad;

  // Data waits on the sink; command words never stall
  assign wr_ready = (state != st_data) || !out_valid || out_ready;

  always_comb begin
    next_state = state;
    case (state)
      st_cmd_a: begin
        if (accept) begin
          next_state = st_cmd_b;
        end
      end
      st_cmd_b: begin
        if (accept) begin
          next_state = empty_buf ? st_cmd_a : st_data;
        end
      end
      st_data: begin
        if (accept && last_dw) begin
          next_state = st_cmd_a;
        end
      end
      default: next_state = st_cmd_a;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_cmd_a;
      cmd_a <= '0;
      idx <= 12'h000;
      size_sum <= 11'h000;
    end else begin
      state <= next_state;
      if ((state == st_cmd_a) && accept) begin
        cmd_a <= wr_as_a;
      end
      if (b_taken) begin
        size_sum <= new_sum;
      end
      if (state != st_data) begin
        idx <= 12'h000;
      end else if (accept) begin
        idx <= idx + 12'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // Payload output register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_word <= '0;
    end else begin
      if (emit) begin
        out_valid <= 1'b1;
        out_word.data <= wr_data;
        out_word.be <= lo_be & hi_be;
        out_word.first <= cmd_a.first_piece_marker && (idx == skip_dw);
        out_word.last <= cmd_a.last_piece_marker && (idx == data_dw - 12'h001);
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Event flags, mask and interrupt
  // ------------------------------------------------------------
  wire wr_access = psel && penable && pwrite;
  wire status_wr = wr_access && (paddr == status_addr);
  wire mask_wr = wr_access && (paddr == mask_addr);
  wire mapped = (paddr == status_addr) || (paddr == mask_addr) || (paddr == info_addr);
  wire [num_flags-1:0] evts = {fault_evt, loaded_evt};

  for (genvar g = 0; g < num_flags; g++) begin : g_flag
    sticky_flag u_flag (
      .pclk(pclk),
      .presetn(presetn),
      .set(evts[g]),
      .clr(status_wr && pwdata[g]),
      .flag(flags[g])
    );
  end

  assign irq = |(flags & mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= mask_reset;
    end else if (mask_wr) begin
      mask <= pwdata[num_flags-1:0];
    end
  end

  // ------------------------------------------------------------
  // APB read path
  // ------------------------------------------------------------
  assign next_rdata = (paddr == status_addr) ? {30'h0, flags} :
                      (paddr == mask_addr) ? {30'h0, mask} :
                      (paddr == info_addr) ? {19'h0, size_sum, state} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data captured in setup so it comes from a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_b_taken;
    (state == st_cmd_b) && accept && !empty_buf;
  endsequence
  sequence s_data_start;
    (state == st_data) && (idx == 12'h000);
  endsequence

  a_loaded_sets_flag: assert property (
    loaded_evt |=> flags[loaded_bit])
    else $error("loaded flag not set after buffer completion");
  a_irq_routes_done: assert property (
    (flags[loaded_bit] && mask[loaded_bit]) |-> irq)
    else $error("unmasked loaded flag does not raise irq");
  a_pad_not_emitted: assert property (
    ((state == st_data) && accept && (idx >= data_dw)) |=> !(out_valid && !$past(out_valid)))
    else $error("padding word reached payload output");
  a_align_total_ok: assert property (
    (state == st_data) |-> ((total_dw & dw_mask) == 12'h000) && (total_dw >= data_dw))
    else $error("buffer length not rounded to alignment");
  a_first_lane_kept: assert property (
    (emit && (idx == skip_dw)) |=> out_word.be[cmd_a.start_off[1:0]] && out_valid)
    else $error("first payload byte lane missing");
  a_offset_skip_drop: assert property (
    ((state == st_data) && accept && (idx < skip_dw)) |=> $stable(out_word.data) || !out_valid)
    else $error("word before start offset was emitted");
  a_first_marker_src: assert property (
    (emit && (idx == skip_dw)) |=> (out_word.first == $past(cmd_a.first_piece_marker)))
    else $error("first marker does not follow first-segment bit");
  a_last_marker_src: assert property (
    (emit && (idx == data_dw - 12'h001)) |=> (out_word.last == $past(cmd_a.last_piece_marker)))
    else $error("last marker does not follow last-segment bit");
  a_len_fault_flag: assert property (
    len_bad |=> flags[fault_bit])
    else $error("length mismatch did not raise fault flag");
  a_sum_restart: assert property (
    (b_taken && cmd_a.first_piece_marker) |=> (size_sum == $past(cmd_a.buf_size)))
    else $error("running size sum did not restart on first segment");
  a_data_after_cmd: assert property (
    s_b_taken |=> s_data_start)
    else $error("data phase did not follow command words");
endmodule // tx_cmd_decode

// [testbench/host_writer.sv]
/*
  Host model: builds buffers and offers command and payload words.
  Assumes wr_ready is sampled at the rising edge of pclk.
*/
`timescale 1ns/100ps

module host_writer import tx_cmd_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Word stream
  input wire logic wr_ready,
  output logic wr_valid,
  output logic [31:0] wr_data
);
  logic [31:0] q[$];

  initial begin
    wr_valid = 1'b0;
    wr_data = 32'h0;
  end

  // ------------------------------
  // Buffer builder
  // ------------------------------
  task automatic send(input cmd_a_s a, input cmd_b_s b, input logic [31:0] base);
    int n;
    int m;
    a.rsvd_hi = 5'h00;
    a.rsvd_mid = 3'h0;
    n = (int'(a.start_off) + int'(a.buf_size) + 3) / 4;
    m = (a.end_align == align_32) ? 8 : ((a.end_align == align_16) ? 4 : 1);
    q.push_back(a);
    q.push_back(b);
    for (int k = 0; k < (n + m - 1) / m * m; k++) begin
      q.push_back(base + 32'(k));
    end
  endtask

  // Held until taken; idle data flips so a stale word never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_valid <= 1'b0;
    end else if (!wr_valid || wr_ready) begin
      wr_valid <= q.size() > 0;
      wr_data <= (q.size() > 0) ? q.pop_front() : ~wr_data;
    end
  end
endmodule // host_writer

// [testbench/tx_buffer_command_word_decode_bench.sv]
/*
  Bench for the command word decoder: APB tasks, host model, stalling sink.
  Assumes a zero-wait APB slave and a registered payload output.
*/
`timescale 1ns/100ps

module tx_buffer_command_word_decode_bench import tx_cmd_pkg::*; ;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wr_valid;
  logic [31:0] wr_data;
  logic wr_ready;
  payload_s out_word;
  logic out_valid;
  logic out_ready;
  logic irq;
  payload_s got[$];
  int n_errors;
  int num_checks;
  logic [31:0] r;
  logic e;

  tx_cmd_decode uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready), .irq(irq));
  host_writer host (.pclk(pclk), .presetn(presetn), .wr_ready(wr_ready),
    .wr_valid(wr_valid), .wr_data(wr_data));

  always #25 pclk = ~pclk;

  // Sink stalls every other cycle
  always @(posedge pclk) begin
    out_ready <= ~out_ready;
    if (out_valid && out_ready) begin
      got.push_back(out_word);
    end
  end

  // ------------------------------
  // Checks and bus tasks
  // ------------------------------
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    n_errors++;
    $display("Error t=%0t %s", $time, msg);
  endtask

  task automatic chk_reg(input logic [31:0] exp, input logic [31:0] act);
    num_checks++;
    if (act !== exp) begin
      fail($sformatf("value %h expected %h", act, exp));
    end
  endtask

  task automatic chk_word(input payload_s exp, input payload_s act);
    num_checks++;
    if (act !== exp) begin
      fail($sformatf("word %h expected %h", act, exp));
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fail("bus hang");
      finish_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(exp, r);
  endtask

  task automatic wait_out(input int n);
    int i;
    for (i = 0; i < 300 && (got.size() < n || host.q.size() > 0 || wr_valid); i++) begin
      @(posedge pclk);
    end
    if (i == 300) begin
      fail("stream hang");
      finish_test;
    end
    repeat (2) @(posedge pclk);
    chk_reg(32'(n), 32'(got.size()));
  endtask

  function automatic cmd_a_s mk_a(input logic dn, input logic [1:0] al, input logic [4:0] off,
    input logic fs, input logic ls, input logic [10:0] sz);
    mk_a = '{dn, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz};
  endfunction

  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    out_ready = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(status_addr, 32'h0);
    rd(mask_addr, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk_reg(32'h1, {31'h0, e});
    $display("test registers done");
    host.send(mk_a(1'b1, align_16, 5'h05, 1'b1, 1'b1, 11'h006),
      cmd_b_s'{16'h0001, 5'h00, 11'h006}, 32'hA5A50000);
    wait_out(2);
    chk_word('{32'hA5A50001, 4'hE, 1'b1, 1'b0}, got[0]);
    chk_word('{32'hA5A50002, 4'h7, 1'b0, 1'b1}, got[1]);
    rd(status_addr, 32'h1);
    chk_reg(32'h0, {31'h0, irq});
    apb(1'b1, mask_addr, 32'h1);
    chk_reg(32'h1, {31'h0, irq});
    apb(1'b1, status_addr, 32'h1);
    chk_reg(32'h0, {31'h0, irq});
    $display("test loaded flag done");
    host.send(mk_a(1'b0, align_32, 5'h00, 1'b1, 1'b1, 11'h004),
      cmd_b_s'{16'h0002, 5'h00, 11'h004}, 32'h5A5A0000);
    wait_out(3);
    chk_word('{32'h5A5A0000, 4'hF, 1'b1, 1'b1}, got[2]);
    rd(status_addr, 32'h0);
    $display("test padding done");
    host.send(mk_a(1'b0, align_4, 5'h02, 1'b1, 1'b0, 11'h003),
      cmd_b_s'{16'h0003, 5'h00, 11'h005}, 32'h3C3C0000);
    host.send(mk_a(1'b1, align_4, 5'h00, 1'b0, 1'b1, 11'h003),
      cmd_b_s'{16'h0003, 5'h00, 11'h005}, 32'h69690000);
    wait_out(6);
    chk_word('{32'h3C3C0000, 4'hC, 1'b1, 1'b0}, got[3]);
    chk_word('{32'h3C3C0001, 4'h1, 1'b0, 1'b0}, got[4]);
    chk_word('{32'h69690000, 4'h7, 1'b0, 1'b1}, got[5]);
    rd(status_addr, 32'h3);
    rd(info_addr, 32'h00000018);
    $display("test packet fault done");
    finish_test;
  end
endmodule // tx_buffer_command_word_decode_bench
